// ===== core/adc_seq_ctrl.sv
// Converter sequencing: triggers, sampling, buffering, completion and DMA pacing
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    // Power state
    input  wire logic        idle_mode_i,
    // Trigger sources
    input  wire logic        ctmu_trig_i,
    input  wire logic        timer5_trig_i,
    input  wire logic        pwm_special_trig_i,
    input  wire logic        timer3_trig_i,
    input  wire logic        ext_edge_trig_i,
    input  wire logic [2:0]  pwm_gen_trig_i,
    input  wire logic [3:0]  gen_out_trig_i,
    // Analog front end
    input  wire logic [11:0] conv_result_i,
    input  wire logic [3:0]  input_index_i,
    input  wire logic        int_enable_i,
    output logic             sampling_o,
    output logic [1:0]       channel_count_o,
    output logic             simultaneous_o,
    output logic             scan_restart_o,
    output logic             res12_o,
    // Completion and DMA
    output logic             irq_o,
    output logic             dma_inc_o,
    output logic [15:0]      dma_addr_o,
    output logic [3:0]       buf_ptr_o
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        seq_state_e    state;
        logic [15:0]   ctrl_one;
        logic [15:0]   ctrl_two;
        logic [15:0]   ctrl_three;
        logic [15:0][15:0] buffer_half_status;
        logic [3:0]    buf_ptr;
        logic [4:0]    samples_per_interrupt_cnt;
        logic [7:0]    timer;
        logic          irq;
        logic          dma_inc;
        logic [15:0]   dma_addr;
        logic          scan_restart;
        logic [3:0]    rsel;
        logic [15:0]   rdata;
    } state_s;

    state_s          cur;
    state_s          next_s;
    logic            trig;
    logic            counter_done;
    logic [15:0]     fmt_data;
    logic            running;
    logic            manual;
    logic [4:0]      samples_per_interrupt;
    logic            dma_en;
    logic            count_hit;
    logic            conv_end;
    logic [15:0]     sg_addr;

    adc_trigger_select u_trig (
        .trigger_source_i   (cur.ctrl_one[`BIT_SRC_HI:`BIT_SRC_LO]),
        .trigger_group_i    (cur.ctrl_one[`BIT_GROUP]),
        .counter_done_i     (counter_done),
        .ctmu_trig_i        (ctmu_trig_i),
        .timer5_trig_i      (timer5_trig_i),
        .pwm_special_trig_i (pwm_special_trig_i),
        .timer3_trig_i      (timer3_trig_i),
        .ext_edge_trig_i    (ext_edge_trig_i),
        .pwm_gen_trig_i     (pwm_gen_trig_i),
        .gen_out_trig_i     (gen_out_trig_i),
        .trig_o             (trig)
    );

    adc_result_format u_fmt (
        .raw_i           (conv_result_i),
        .res12_i         (cur.ctrl_one[`BIT_RES12]),
        .output_format_i (cur.ctrl_one[`BIT_FMT_HI:`BIT_FMT_LO]),
        .data_o          (fmt_data)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        running = cur.ctrl_one[`BIT_ON] & ~(cur.ctrl_one[`BIT_SIDL] & idle_mode_i);
        manual = (cur.ctrl_one[`BIT_SRC_HI:`BIT_SRC_LO] == 3'h0) & ~cur.ctrl_one[`BIT_GROUP];
        samples_per_interrupt = cur.ctrl_two[`BIT_SAMPLES_PER_INTERRUPT_HI:`BIT_SAMPLES_PER_INTERRUPT_LO];
        dma_en = cur.ctrl_three[`BIT_DMA_EN];
        counter_done = (cur.timer == 8'(`AUTO_SAMPLE_CYCLES));
        conv_end = (cur.state == ST_CONV) && (cur.timer == 8'(`CONV_CYCLES - 1));
        // Limit of 16 without DMA, 32 with it
        count_hit = dma_en ? (cur.samples_per_interrupt_cnt == samples_per_interrupt) : (cur.samples_per_interrupt_cnt[3:0] == samples_per_interrupt[3:0]);
        // Scatter/gather slot from input index times 16, ORed with the sample count
        sg_addr = {8'h00, input_index_i, 4'h0} | {11'h000, cur.samples_per_interrupt_cnt};
    end

    always_comb begin
        next_s = cur;
        next_s.irq = 1'b0;
        next_s.dma_inc = 1'b0;
        next_s.scan_restart = 1'b0;
        // Register writes
        if (wr_i) begin
            case (addr_i)
                `OFS_CTRL_ONE: begin
                    // Software can clear, never set, the completion flag
                    next_s.ctrl_one = (wdata_i & `CTRL_ONE_WMASK)
                                    | (cur.ctrl_one & ~`CTRL_ONE_WMASK & wdata_i & 16'h0001);
                    if (wdata_i[`BIT_RES12])
                        next_s.ctrl_one[`BIT_SIMUL] = 1'b0;
                end
                `OFS_CTRL_TWO:    next_s.ctrl_two = wdata_i & `CTRL_TWO_WMASK;
                `OFS_CTRL_THREE:  next_s.ctrl_three = wdata_i;
                `OFS_RESULT_SEL:  next_s.rsel = wdata_i[3:0];
                default: ;
            endcase
        end
        if (!cur.ctrl_one[`BIT_ON]) begin
            next_s.state = ST_OFF;
            next_s.samples_per_interrupt_cnt = 5'h00;
            next_s.buf_ptr = 4'h0;
            next_s.timer = 8'h00;
        end else if (running) begin
            case (cur.state)
                ST_OFF: begin
                    next_s.state = ST_IDLE;
                end
                ST_IDLE: begin
                    if (next_s.ctrl_one[`BIT_SAMPLE]) begin
                        next_s.state = ST_SAMPLE;
                        next_s.timer = 8'h00;
                    end
                end
                ST_SAMPLE: begin
                    next_s.timer = cur.timer + 8'h01;
                    if (manual ? !next_s.ctrl_one[`BIT_SAMPLE] : trig) begin
                        next_s.ctrl_one[`BIT_SAMPLE] = 1'b0;
                        next_s.ctrl_one[`BIT_DONE] = 1'b0;
                        next_s.state = ST_CONV;
                        next_s.timer = 8'h00;
                    end
                end
                ST_CONV: begin
                    next_s.timer = cur.timer + 8'h01;
                    if (conv_end) begin
                        next_s.ctrl_one[`BIT_DONE] = 1'b1;
                        next_s.timer = 8'h00;
                        if (dma_en) begin
                            next_s.buffer_half_status[0] = fmt_data;
                            next_s.buf_ptr = 4'h0;
                        end else begin
                            next_s.buffer_half_status[cur.buf_ptr] = fmt_data;
                            next_s.buf_ptr = count_hit ? 4'h0 : cur.buf_ptr + 4'h1;
                        end
                        if (count_hit) begin
                            next_s.samples_per_interrupt_cnt = 5'h00;
                            next_s.irq = int_enable_i;
                            next_s.scan_restart = cur.ctrl_two[`BIT_SCAN];
                            if (dma_en) begin
                                next_s.dma_inc = 1'b1;
                                next_s.dma_addr = cur.ctrl_one[`BIT_BUILD]
                                                ? cur.dma_addr + 16'h0001
                                                : sg_addr;
                            end
                        end else begin
                            next_s.samples_per_interrupt_cnt = cur.samples_per_interrupt_cnt + 5'h01;
                        end
                        if (cur.ctrl_one[`BIT_AUTO]) begin
                            next_s.ctrl_one[`BIT_SAMPLE] = 1'b1;
                            next_s.state = ST_SAMPLE;
                        end else begin
                            next_s.state = ST_IDLE;
                        end
                    end
                end
                default: next_s.state = ST_OFF;
            endcase
        end
        // Read data one cycle after the strobe
        next_s.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                `OFS_CTRL_ONE:   next_s.rdata = cur.ctrl_one;
                `OFS_CTRL_TWO:   next_s.rdata = cur.ctrl_two;
                `OFS_CTRL_THREE: next_s.rdata = cur.ctrl_three;
                `OFS_RESULT_SEL: next_s.rdata = cur.buffer_half_status[cur.rsel];
                `OFS_DMA_STATUS: next_s.rdata = cur.dma_addr;
                default:         next_s.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur <= '0;
        end else begin
            cur <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign rdata_o         = cur.rdata;
    assign sampling_o      = (cur.state == ST_SAMPLE);
    assign res12_o         = cur.ctrl_one[`BIT_RES12];
    assign channel_count_o = cur.ctrl_one[`BIT_RES12] ? 2'h0 : cur.ctrl_two[`BIT_CHANNEL_COUNT_SELECT_HI:`BIT_CHANNEL_COUNT_SELECT_LO];
    assign simultaneous_o  = cur.ctrl_one[`BIT_SIMUL] & ~cur.ctrl_one[`BIT_RES12];
    assign scan_restart_o  = cur.scan_restart;
    assign irq_o           = cur.irq;
    assign dma_inc_o       = cur.dma_inc;
    assign dma_addr_o      = cur.dma_addr;
    assign buf_ptr_o       = cur.buf_ptr;

    ////////////////////////////////////////////////////////////////////////
    done_clear_at_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.state == ST_SAMPLE && $past(cur.state) == ST_SAMPLE) ##0 (next_s.state == ST_CONV && running)
        |=> !cur.ctrl_one[`BIT_DONE]) else $error("done not cleared at conversion start");
    done_with_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (conv_end && running) |=> cur.ctrl_one[`BIT_DONE]) else $error("done not set at completion");
    dma_buf_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (conv_end && running && dma_en) |=> cur.buffer_half_status[0] == $past(fmt_data)) else $error("dma result misplaced");
    off_clears_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !cur.ctrl_one[`BIT_ON] |=> (cur.samples_per_interrupt_cnt == 5'h00 && cur.buf_ptr == 4'h0)) else $error("count kept");
    irq_on_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        irq_o |-> $past(count_hit && conv_end && int_enable_i)) else $error("irq without count");
    simul_in_12bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        res12_o |-> !cur.ctrl_one[`BIT_SIMUL]) else $error("simultaneous in 12-bit");
    auto_resample_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (conv_end && running && cur.ctrl_one[`BIT_AUTO]) |=> sampling_o ##0 cur.ctrl_one[`BIT_SAMPLE])
        else $error("auto sample missing");
    hw_clear_sample_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sampling_o && running && !manual && trig) |=> (cur.state == ST_CONV && !cur.ctrl_one[`BIT_SAMPLE]))
        else $error("trigger did not end sampling");
    ptr_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (conv_end && running && !dma_en && count_hit) |=> buf_ptr_o == 4'h0) else $error("pointer not wrapped");
    stop_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.ctrl_one[`BIT_SIDL] && idle_mode_i && cur.ctrl_one[`BIT_ON] && !wr_i) |=> $stable(cur.state))
        else $error("ran in idle");

endmodule

// ===== core/adc_seq_cfg.svh
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

`define OFS_CTRL_ONE      4'h0
`define OFS_CTRL_TWO      4'h1
`define OFS_RESULT_BASE   4'h0
`define OFS_RESULT_SEL    4'h2
`define OFS_DMA_STATUS    4'h3
`define OFS_CTRL_THREE    4'h4
`define OFS_RESULT_WIN    4'h8

`define CTRL_ONE_RESET    16'h0000
`define CTRL_TWO_RESET    16'h0000
`define CTRL_THREE_RESET  16'h0000

`define BIT_ON            15
`define BIT_SIDL          13
`define BIT_BUILD         12
`define BIT_RES12         10
`define BIT_FMT_HI        9
`define BIT_FMT_LO        8
`define BIT_SRC_HI        7
`define BIT_SRC_LO        5
`define BIT_GROUP         4
`define BIT_SIMUL         3
`define BIT_AUTO          2
`define BIT_SAMPLE        1
`define BIT_DONE          0
`define BIT_SCAN          10
`define BIT_CHANNEL_COUNT_SELECT_HI       9
`define BIT_CHANNEL_COUNT_SELECT_LO       8
`define BIT_SAMPLES_PER_INTERRUPT_HI       6
`define BIT_SAMPLES_PER_INTERRUPT_LO       2
`define BIT_DMA_EN        8

`define CTRL_ONE_WMASK    16'hb7fe
`define CTRL_TWO_WMASK    16'h077f

`define CONV_TIME_NS      240
`define CLK_PERIOD_NS     20
`define CONV_CYCLES       ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AUTO_SAMPLE_CYCLES 4

`endif

// ===== core/adc_seq_pkg.sv
// Types shared by the converter sequencing logic
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_OFF    = 2'b00,
        ST_IDLE   = 2'b01,
        ST_SAMPLE = 2'b11,
        ST_CONV   = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic [15:0] inc_addr;
        logic        inc;
    } dma_req_s;

endpackage

// ===== core/adc_trigger_select.sv
// Trigger source selection that ends sampling
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_trigger_select
    import adc_seq_pkg::*;
(
    // Selection
    input  wire logic [2:0] trigger_source_i,
    input  wire logic       trigger_group_i,
    input  wire logic       counter_done_i,
    // Event sources
    input  wire logic       ctmu_trig_i,
    input  wire logic       timer5_trig_i,
    input  wire logic       pwm_special_trig_i,
    input  wire logic       timer3_trig_i,
    input  wire logic       ext_edge_trig_i,
    input  wire logic [2:0] pwm_gen_trig_i,
    input  wire logic [3:0] gen_out_trig_i,
    // Result
    output logic            trig_o
);

    always_comb begin
        trig_o = 1'b0;
        if (!trigger_group_i) begin
            case (trigger_source_i)
                3'h7:    trig_o = counter_done_i;
                3'h6:    trig_o = ctmu_trig_i;
                3'h4:    trig_o = timer5_trig_i;
                3'h3:    trig_o = pwm_special_trig_i;
                3'h2:    trig_o = timer3_trig_i;
                3'h1:    trig_o = ext_edge_trig_i;
                default: trig_o = 1'b0;
            endcase
        end else begin
            case (trigger_source_i)
                3'h0:    trig_o = pwm_gen_trig_i[0];
                3'h1:    trig_o = pwm_gen_trig_i[1];
                3'h2:    trig_o = pwm_gen_trig_i[2];
                3'h3:    trig_o = gen_out_trig_i[0];
                3'h4:    trig_o = gen_out_trig_i[1];
                3'h5:    trig_o = gen_out_trig_i[2];
                3'h6:    trig_o = gen_out_trig_i[3];
                default: trig_o = 1'b0;
            endcase
        end
    end

endmodule

// ===== core/adc_result_format.sv
// Result layout for 10-bit and 12-bit conversions
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_result_format
    import adc_seq_pkg::*;
(
    // Raw result and mode
    input  wire logic [11:0] raw_i,
    input  wire logic        res12_i,
    input  wire logic [1:0]  output_format_i,
    // Formatted result
    output logic [15:0]      data_o
);

    logic [9:0]  d10;
    logic        s10;
    logic        s12;

    always_comb begin
        d10 = raw_i[9:0];
        s10 = ~raw_i[9];
        s12 = ~raw_i[11];
        data_o = 16'h0000;
        if (!res12_i) begin
            case (output_format_i)
                2'h3:    data_o = {s10, d10[8:0], 6'h00};
                2'h2:    data_o = {d10, 6'h00};
                2'h1:    data_o = {{7{s10}}, d10[8:0]};
                default: data_o = {6'h00, d10};
            endcase
        end else begin
            case (output_format_i)
                2'h3:    data_o = {s12, raw_i[10:0], 4'h0};
                2'h2:    data_o = {raw_i, 4'h0};
                2'h1:    data_o = {{5{s12}}, raw_i[10:0]};
                default: data_o = {4'h0, raw_i};
            endcase
        end
    end

endmodule

// ===== bench/dma_reader_model.sv
// Far-side model: DMA controller and processor taking completion events
`timescale 1ns/1ps

module dma_reader_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Events from the sequencer
    input  wire logic        sampling_i,
    input  wire logic        irq_i,
    input  wire logic        dma_inc_i,
    input  wire logic        scan_restart_i,
    input  wire logic [15:0] dma_addr_i,
    input  wire logic [3:0]  buf_ptr_i,
    // Observations
    output logic [15:0]      n_irq_o,
    output logic [15:0]      n_inc_o,
    output logic [15:0]      rises_o,
    output logic [7:0]       gap_o,
    output logic [3:0]       ptr_at_irq_o,
    output logic             scan_at_irq_o,
    output logic [15:0]      addr_at_inc_o
);
    logic       sample_enable_q;
    logic       rise;
    logic [7:0] since;

    assign rise = sampling_i && !sample_enable_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Taken in the event cycle itself, since the next completion overwrites buffer zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {sample_enable_q, since, n_irq_o, n_inc_o, rises_o, gap_o} <= '0;
            {ptr_at_irq_o, scan_at_irq_o, addr_at_inc_o} <= '0;
        end else begin
            sample_enable_q  <= sampling_i;
            rises_o <= rises_o + {15'h0000, rise};
            since   <= (irq_i || dma_inc_i) ? {7'h00, rise} : since + {7'h00, rise};
            if (irq_i || dma_inc_i) begin
                gap_o <= since;
            end
            if (irq_i) begin
                n_irq_o       <= n_irq_o + 16'h0001;
                ptr_at_irq_o  <= buf_ptr_i;
                scan_at_irq_o <= scan_restart_i;
            end
            if (dma_inc_i) begin
                n_inc_o       <= n_inc_o + 16'h0001;
                addr_at_inc_o <= dma_addr_i;
            end
        end
    end
endmodule

// ===== bench/adc_sequencing_control_bench.sv
// Self-checking bench for the converter sequencing block
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_sequencing_control_bench;
    logic        clk_i, rst_n_i, wr_i, rd_i, idle_mode_i, int_enable_i;
    logic [3:0]  addr_i, input_index_i, buf_ptr_o, ptr_at_irq;
    logic [15:0] wdata_i, rdata_o, dma_addr_o, n_irq, n_inc, rises, addr_at_inc, r, q;
    logic [11:0] trig, conv_result_i;
    logic [7:0]  gap;
    logic [1:0]  channel_count_o;
    logic        sampling_o, simultaneous_o, scan_restart_o, res12_o, irq_o, dma_inc_o, scan_at_irq;
    int          error_cnt, n_tests;
    int          tidx [16] = '{-2, 4, 3, 2, 1, -1, 0, -2, 5, 6, 7, 8, 9, 10, 11, -1};

    adc_seq_ctrl adc_seq_ctrl_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .idle_mode_i(idle_mode_i), .ctmu_trig_i(trig[0]), .timer5_trig_i(trig[1]),
        .pwm_special_trig_i(trig[2]), .timer3_trig_i(trig[3]), .ext_edge_trig_i(trig[4]),
        .pwm_gen_trig_i(trig[7:5]), .gen_out_trig_i(trig[11:8]), .conv_result_i(conv_result_i),
        .input_index_i(input_index_i), .int_enable_i(int_enable_i), .sampling_o(sampling_o),
        .channel_count_o(channel_count_o), .simultaneous_o(simultaneous_o), .scan_restart_o(scan_restart_o),
        .res12_o(res12_o), .irq_o(irq_o), .dma_inc_o(dma_inc_o), .dma_addr_o(dma_addr_o), .buf_ptr_o(buf_ptr_o)
    );

    dma_reader_model dma_reader_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sampling_i(sampling_o), .irq_i(irq_o), .dma_inc_i(dma_inc_o),
        .scan_restart_i(scan_restart_o), .dma_addr_i(dma_addr_o), .buf_ptr_i(buf_ptr_o), .n_irq_o(n_irq),
        .n_inc_o(n_inc), .rises_o(rises), .gap_o(gap), .ptr_at_irq_o(ptr_at_irq), .scan_at_irq_o(scan_at_irq),
        .addr_at_inc_o(addr_at_inc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask

    // Settle time after the taking edge so register-derived levels can be compared
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask

    task rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk(rdata_o, e);
    endtask

    function automatic logic [15:0] fmt(input logic [11:0] x, input logic h, input logic [1:0] f);
        case ({h, f})
            3'b000: fmt = {6'h00, x[9:0]};
            3'b001: fmt = {{7{~x[9]}}, x[8:0]};
            3'b010: fmt = {x[9:0], 6'h00};
            3'b011: fmt = {~x[9], x[8:0], 6'h00};
            3'b100: fmt = {4'h0, x};
            3'b101: fmt = {{5{~x[11]}}, x[10:0]};
            3'b110: fmt = {x, 4'h0};
            default: fmt = {~x[11], x[10:0], 4'h0};
        endcase
    endfunction

    task manual(input logic [15:0] c);
        wr(`OFS_CTRL_ONE, c | 16'h0002);
        repeat (3) @(posedge clk_i);
        wr(`OFS_CTRL_ONE, c);
        rchk(`OFS_CTRL_ONE, c);
        repeat (16) @(posedge clk_i);
        rchk(`OFS_CTRL_ONE, c | 16'h0001);
    endtask

    // Wrong sources are pulsed first, so a miswired select shows up as an early conversion
    task trig_try(input int i);
        logic [15:0] c;
        c = {8'h80, i[2:0], i[3], 4'h0};
        wr(`OFS_CTRL_ONE, c | 16'h0002);
        repeat (2) @(posedge clk_i);
        trig <= (tidx[i] < 0) ? 12'hfff : ~(12'h001 << tidx[i]);
        @(posedge clk_i);
        trig <= 12'h000;
        repeat (3) @(posedge clk_i);
        chk(sampling_o, 1'b1);
        if (tidx[i] >= 0) begin
            trig <= 12'h001 << tidx[i];
            @(posedge clk_i);
            trig <= 12'h000;
            repeat (16) @(posedge clk_i);
            rchk(`OFS_CTRL_ONE, c | 16'h0001);
        end
        wr(`OFS_CTRL_ONE, 16'h0000);
    endtask

    task test_done;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n_i, wr_i, rd_i, idle_mode_i, addr_i, wdata_i, input_index_i, trig} = '0;
        int_enable_i  = 1'b1;
        conv_result_i = 12'hba5;
        error_cnt     = 0;
        n_tests       = 0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rchk(`OFS_CTRL_ONE, `CTRL_ONE_RESET);
        rchk(`OFS_CTRL_TWO, `CTRL_TWO_RESET);
        rchk(`OFS_CTRL_THREE, `CTRL_THREE_RESET);
        rchk(4'hf, 16'h0000);
        wr(`OFS_CTRL_ONE, 16'h0409);
        rchk(`OFS_CTRL_ONE, 16'h0400);
        chk(res12_o, 1'b1);
        wr(`OFS_CTRL_ONE, 16'h0002);
        repeat (4) @(posedge clk_i);
        chk(sampling_o, 1'b0);
        wr(`OFS_CTRL_ONE, 16'h0008);
        chk(simultaneous_o, 1'b1);
        chk(res12_o, 1'b0);
        wr(`OFS_CTRL_TWO, 16'h0200);
        chk(channel_count_o, 2'b10);
        wr(`OFS_CTRL_TWO, 16'h0000);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_i) conv_result_i <= v[0] ? 12'h45a : 12'hba5;
            for (int h = 0; h < 2; h++) begin
                wr(`OFS_CTRL_ONE, 16'h0000);
                for (int f = 0; f < 4; f++) begin
                    manual({1'b1, 4'h0, h[0], f[1:0], 8'h00});
                    wr(`OFS_RESULT_SEL, 16'h0000);
                    rchk(`OFS_RESULT_SEL, fmt(conv_result_i, h[0], f[1:0]));
                end
            end
        end
        wr(`OFS_CTRL_ONE, 16'h0000);
        for (int i = 0; i < 16; i++) if (tidx[i] != -2) trig_try(i);
        wr(`OFS_CTRL_TWO, 16'h040c);
        rchk(`OFS_CTRL_TWO, 16'h040c);
        wr(`OFS_CTRL_ONE, 16'ha0e6);
        r = n_irq + 16'd3;
        for (int k = 0; k < 800 && n_irq != r; k++) @(posedge clk_i);
        chk(n_irq, r);
        chk({8'h00, gap}, 16'h0004);
        chk(ptr_at_irq, 4'h0);
        chk(scan_at_irq, 1'b1);
        for (int b = 0; b < 4; b++) begin
            wr(`OFS_RESULT_SEL, b[15:0]);
            rchk(`OFS_RESULT_SEL, fmt(conv_result_i, 1'b0, 2'b00));
        end
        @(posedge clk_i) idle_mode_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        r = rises;
        repeat (100) @(posedge clk_i);
        chk(rises, r);
        wr(`OFS_CTRL_ONE, 16'h0000);
        wr(`OFS_CTRL_ONE, 16'h80e6);
        repeat (100) @(posedge clk_i);
        chk(rises > r, 1'b1);
        @(posedge clk_i) idle_mode_i <= 1'b0;
        @(posedge clk_i) int_enable_i <= 1'b0;
        // A pulse launched at the disabling edge is counted one edge later
        repeat (2) @(posedge clk_i);
        r = n_irq;
        repeat (200) @(posedge clk_i);
        chk(n_irq, r);
        @(posedge clk_i) int_enable_i <= 1'b1;
        wr(`OFS_CTRL_ONE, 16'h0000);
        repeat (2) @(posedge clk_i);
        chk(buf_ptr_o, 4'h0);
        chk(sampling_o, 1'b0);
        @(posedge clk_i) input_index_i <= 4'h3;
        wr(`OFS_CTRL_THREE, 16'h0100);
        wr(`OFS_CTRL_TWO, 16'h0004);
        wr(`OFS_CTRL_ONE, 16'h80e6);
        r = n_inc + 16'd2;
        for (int k = 0; k < 400 && n_inc != r; k++) @(posedge clk_i);
        chk(n_inc, r);
        chk({8'h00, gap}, 16'h0002);
        chk(buf_ptr_o, 4'h0);
        chk({4'h0, addr_at_inc[15:4]}, 16'h0003);
        wr(`OFS_RESULT_SEL, 16'h0000);
        rchk(`OFS_RESULT_SEL, fmt(conv_result_i, 1'b0, 2'b00));
        wr(`OFS_CTRL_ONE, 16'h0000);
        // Conversion-order build: address steps by one per increment
        q = dma_addr_o + 16'd2;
        wr(`OFS_CTRL_ONE, 16'h90e6);
        r = n_inc + 16'd2;
        for (int k = 0; k < 400 && n_inc != r; k++) @(posedge clk_i);
        chk(n_inc, r);
        chk(addr_at_inc, q);
        wr(`OFS_CTRL_ONE, 16'h0000);
        test_done;
    end
endmodule
